// ### hw/start_decode_output_select.sv
// Purpose: Decodes start inputs into run and direction, and routes status functions to terminals.
// Assumes: Start, stop-hold, jog and output-stop come from pins; the rest is core logic.
// Notes:   Functions not produced here read inactive on any terminal that selects them.
`timescale 1ns/10ps

module start_decode_output_select
	import sdos_pkg::*;
#(
	parameter int QUAL_W = 24
) (
	input  wire logic              i_core_clk,           // Core clock, 100 MHz.
	input  wire logic              i_reset,              // Synchronous reset, high.
	input  wire logic              i_forward_start_in,   // Forward start pin.
	input  wire logic              i_reverse_start_in,   // Reverse start pin.
	input  wire logic              i_stop_hold_in,       // Stop-hold pin, high holds.
	input  wire logic              i_jog_in,             // Jog request pin.
	input  wire logic              i_output_stop_in,     // Output-stop pin.
	input  wire logic              i_jog_enable,         // Jog operation allowed.
	input  wire logic [SEL_W-1:0]  i_start_selection,    // Start selection setting.
	input  wire logic [SEL_W-1:0]  i_run_terminal_sel,   // Run terminal code.
	input  wire logic [SEL_W-1:0]  i_freq_terminal_sel,  // Frequency terminal code.
	input  wire logic [SEL_W-1:0]  i_relay_terminal_sel, // Relay terminal code.
	input  wire logic [FREQ_W-1:0] i_out_freq,           // Present output frequency.
	input  wire logic [FREQ_W-1:0] i_start_freq,         // Starting frequency.
	input  wire logic [FREQ_W-1:0] i_set_freq,           // Set frequency.
	input  wire logic [FREQ_W-1:0] i_detect_freq_fwd,    // Detect level, forward.
	input  wire logic [FREQ_W-1:0] i_detect_freq_rev,    // Detect level, reverse.
	input  wire logic              i_stall_active,       // Stall prevention active.
	input  wire logic [PCT_W-1:0]  i_regen_usage_pct,    // Regen usage, percent of duty.
	input  wire logic [PCT_W-1:0]  i_thermal_pct,        // Thermal cumulative, percent.
	input  wire logic [FREQ_W-1:0] i_out_current,        // Output current.
	input  wire logic [FREQ_W-1:0] i_current_limit,      // Current detect threshold.
	input  wire logic [QUAL_W-1:0] i_current_qual,       // Qualification time, cycles.
	input  wire logic              i_fault_active,       // Drive fault present.
	output      logic              o_run_cmd,            // Run command.
	output      logic              o_dir_reverse,        // Direction, high is reverse.
	output      logic              o_output_on,          // Output bridge enabled.
	output      logic              o_coast_stop,         // Stop by coasting.
	output      logic              o_jog_active,         // Jog in force.
	output      logic              o_thermal_trip,       // Thermal trip, sticky.
	output      logic              o_run_term,           // Run open-collector terminal.
	output      logic              o_freq_term,          // Frequency open-collector terminal.
	output      logic              o_relay_term          // Relay terminal.
);

	// ********************************************************
	// Pin synchronisers
	// ********************************************************
	logic [4:0] pin_meta_reg;
	logic [4:0] pin_sync_reg;
	logic [4:0] pin_prev_reg;
	logic [4:0] pins_in;

	assign pins_in = {i_output_stop_in, i_jog_in, i_stop_hold_in,
		i_reverse_start_in, i_forward_start_in};

	// Two flops per pin, then one more stage for edge detection.
	always_ff @(posedge i_core_clk) begin
		if (i_reset) begin
			pin_meta_reg <= 5'h00;
			pin_sync_reg <= 5'h00;
			pin_prev_reg <= 5'h00;
		end else begin
			pin_meta_reg <= pins_in;
			pin_sync_reg <= pin_meta_reg;
			pin_prev_reg <= pin_sync_reg;
		end
	end

	logic fwd_s;
	logic rev_s;
	logic hold_s;
	logic jog_s;
	logic ostop_s;
	logic fwd_rise;
	logic rev_rise;

	assign fwd_s    = pin_sync_reg[0];
	assign rev_s    = pin_sync_reg[1];
	assign hold_s   = pin_sync_reg[2];
	assign jog_s    = pin_sync_reg[3];
	assign ostop_s  = pin_sync_reg[4];
	assign fwd_rise = fwd_s && !pin_prev_reg[0];
	assign rev_rise = rev_s && !pin_prev_reg[1];

	// ********************************************************
	// Settings registers
	// ********************************************************
	logic [SEL_W-1:0] start_sel_reg;
	sdos_func_if      fbus ();

	// Settings take their documented values in reset, then follow the ports.
	always_ff @(posedge i_core_clk) begin
		if (i_reset) begin
			start_sel_reg    <= START_SEL_RST;
			fbus.term_sel[0] <= RUN_SEL_RST;
			fbus.term_sel[1] <= FREQ_SEL_RST;
			fbus.term_sel[2] <= RELAY_SEL_RST;
		end else begin
			start_sel_reg    <= i_start_selection;
			fbus.term_sel[0] <= i_run_terminal_sel;
			fbus.term_sel[1] <= i_freq_terminal_sel;
			fbus.term_sel[2] <= i_relay_terminal_sel;
		end
	end

	logic mode_rundir;
	logic mode_coast;

	// Run/direction interpretation and coast-stop choice from the start setting.
	assign mode_rundir = (start_sel_reg == START_RUNDIR_DEC) ||
		((start_sel_reg >= START_RUNDIR_MIN) && (start_sel_reg <= START_RUNDIR_MAX));
	assign mode_coast  = (start_sel_reg <= START_TIME_MAX) ||
		((start_sel_reg >= START_RUNDIR_MIN) && (start_sel_reg <= START_RUNDIR_MAX));

	// ********************************************************
	// Self-hold
	// ********************************************************
	logic jog_on;
	logic hold_valid;
	logic hold_fwd_reg;
	logic hold_rev_reg;
	logic hold_fwd_next;
	logic hold_rev_next;

	// Jog overrides stop-hold; output stop does not touch the latches.
	assign jog_on        = jog_s && i_jog_enable;
	assign hold_valid    = hold_s && !jog_on;
	// A start pulse latches its own input; a pulse on the other input replaces it.
	assign hold_fwd_next = hold_valid && (fwd_rise || (hold_fwd_reg && !rev_rise));
	assign hold_rev_next = hold_valid && (rev_rise || (hold_rev_reg && !fwd_rise));

	always_ff @(posedge i_core_clk) begin
		if (i_reset) begin
			hold_fwd_reg <= 1'b0;
			hold_rev_reg <= 1'b0;
		end else begin
			hold_fwd_reg <= hold_fwd_next;
			hold_rev_reg <= hold_rev_next;
		end
	end

	// ********************************************************
	// Start decode
	// ********************************************************
	logic eff_fwd;
	logic eff_rev;
	logic run_next;
	logic rev_next;

	// In self-hold the inputs only trigger, the latches carry the command.
	assign eff_fwd  = hold_valid ? hold_fwd_next : fwd_s;
	assign eff_rev  = hold_valid ? hold_rev_next : rev_s;
	// Two-start: exactly one input runs. Run/direction: forward runs, reverse flips.
	assign run_next = mode_rundir ? eff_fwd : (eff_fwd ^ eff_rev);
	assign rev_next = mode_rundir ? (eff_fwd && eff_rev) : (eff_rev && !eff_fwd);

	logic run_reg;
	logic dir_reg;
	logic on_reg;
	logic coast_reg;
	logic jog_reg;
	logic trip_reg;

	// Command registers; direction holds its last value while stopped.
	always_ff @(posedge i_core_clk) begin
		if (i_reset) begin
			run_reg   <= 1'b0;
			dir_reg   <= 1'b0;
			on_reg    <= 1'b0;
			coast_reg <= 1'b0;
			jog_reg   <= 1'b0;
		end else begin
			run_reg   <= run_next;
			dir_reg   <= run_next ? rev_next : dir_reg;
			on_reg    <= (run_next || jog_on) && !ostop_s && !trip_reg;
			coast_reg <= mode_coast;
			jog_reg   <= jog_on;
		end
	end

	// ********************************************************
	// Status functions
	// ********************************************************
	logic [QUAL_W-1:0] cur_cnt_reg;
	logic [QUAL_W-1:0] cur_cnt_next;
	logic              cur_over;
	logic              running;

	// Count cycles over the threshold, saturating; any dip restarts the count.
	assign cur_over     = i_out_current > i_current_limit;
	assign cur_cnt_next = !cur_over ? '0 :
		(&cur_cnt_reg) ? cur_cnt_reg : cur_cnt_reg + 1'b1;
	assign running      = on_reg && (i_out_freq >= i_start_freq);

	// Counter and sticky thermal trip.
	always_ff @(posedge i_core_clk) begin
		if (i_reset) begin
			cur_cnt_reg <= '0;
			trip_reg    <= 1'b0;
		end else begin
			cur_cnt_reg <= cur_cnt_next;
			trip_reg    <= trip_reg || (i_thermal_pct >= TRIP_PCT);
		end
	end

	logic [FUNC_N-1:0] func_vec;

	// One bit per function code; codes without a source here stay low.
	always_comb begin
		func_vec                = '0;
		func_vec[FN_RUNNING]    = running;
		func_vec[FN_AT_SPEED]   = on_reg && (i_out_freq >= i_set_freq);
		func_vec[FN_OVERLOAD]   = i_stall_active;
		func_vec[FN_FREQ_DET]   = i_out_freq >= (dir_reg ? i_detect_freq_rev :
			i_detect_freq_fwd);
		func_vec[FN_REGEN_PRE]  = i_regen_usage_pct >= PREALARM_PCT;
		func_vec[FN_THERM_PRE]  = i_thermal_pct >= PREALARM_PCT;
		func_vec[FN_OP_READY]   = (!i_fault_active && !trip_reg && !ostop_s) || running;
		func_vec[FN_CUR_DETECT] = cur_over && (cur_cnt_reg > i_current_qual);
		func_vec[FN_FAULT]      = i_fault_active || trip_reg;
	end

	assign fbus.func_vec = func_vec;

	// ********************************************************
	// Terminal selectors
	// ********************************************************
	logic [TERM_N-1:0] term;

	// Terminal 2 is the relay, which may not take the pulse monitor.
	for (genvar t = 0; t < TERM_N; t++) begin : g_term
		term_select #(
			.IDX   (t),
			.RELAY (t == 2)
		) u_term (
			.i_core_clk (i_core_clk),
			.i_reset    (i_reset),
			.fbus       (fbus),
			.o_term     (term[t])
		);
	end

	assign o_run_cmd      = run_reg;
	assign o_dir_reverse  = dir_reg;
	assign o_output_on    = on_reg;
	assign o_coast_stop   = coast_reg;
	assign o_jog_active   = jog_reg;
	assign o_thermal_trip = trip_reg;
	assign o_run_term     = term[0];
	assign o_freq_term    = term[1];
	assign o_relay_term   = term[2];

endmodule

// ### hw/sdos_pkg.sv
// Purpose: Shared constants, function codes and helpers for start decode and output select.
// Assumes: Selection codes are unsigned integers, frequencies share one unsigned scale.
// Notes:   Percent inputs are whole percent, 0 to 255.
package sdos_pkg;

	// ********************************************************
	// Widths
	// ********************************************************
	localparam int SEL_W  = 14;
	localparam int FREQ_W = 16;
	localparam int PCT_W  = 8;
	localparam int FUNC_N = 100;
	localparam int TERM_N = 3;

	// ********************************************************
	// Start selection settings
	// ********************************************************
	localparam logic [SEL_W-1:0] START_TIME_MAX   = 14'h0064; // 100 s, coast window end.
	localparam logic [SEL_W-1:0] START_RUNDIR_MIN = 14'h03E8; // 1000.
	localparam logic [SEL_W-1:0] START_RUNDIR_MAX = 14'h044C; // 1100.
	localparam logic [SEL_W-1:0] START_RUNDIR_DEC = 14'h22B8; // 8888.
	localparam logic [SEL_W-1:0] SEL_NONE         = 14'h270F; // 9999.
	localparam logic [SEL_W-1:0] START_SEL_RST    = 14'h270F; // 9999 after reset.

	// ********************************************************
	// Terminal selection reset values and code split
	// ********************************************************
	localparam logic [SEL_W-1:0] RUN_SEL_RST   = 14'h0000;
	localparam logic [SEL_W-1:0] FREQ_SEL_RST  = 14'h0004;
	localparam logic [SEL_W-1:0] RELAY_SEL_RST = 14'h0063;
	localparam logic [SEL_W-1:0] SINK_OFFSET   = 14'h0064; // 100.
	localparam logic [SEL_W-1:0] SINK_MAX      = 14'h00C7; // 199.

	// ********************************************************
	// Function codes (source logic numbering)
	// ********************************************************
	localparam int FN_RUNNING    = 0;
	localparam int FN_AT_SPEED   = 1;
	localparam int FN_OVERLOAD   = 3;
	localparam int FN_FREQ_DET   = 4;
	localparam int FN_REGEN_PRE  = 7;
	localparam int FN_THERM_PRE  = 8;
	localparam int FN_OP_READY   = 11;
	localparam int FN_CUR_DETECT = 12;
	localparam int FN_CUR_AVG    = 93;
	localparam int FN_FAULT      = 99;

	// ********************************************************
	// Thresholds
	// ********************************************************
	localparam logic [PCT_W-1:0] PREALARM_PCT = 8'h55; // 85 %.
	localparam logic [PCT_W-1:0] TRIP_PCT     = 8'h64; // 100 %.

	// Which base codes a terminal may take; the relay cannot take the pulse monitor.
	function automatic logic code_allowed(input logic [SEL_W-1:0] base, input logic relay);
		logic ok;
		ok = 1'b0;
		case (base)
			0, 1, 3, 4, 7, 8, 11, 12, 13, 14, 15, 16, 20, 25, 26, 46, 47, 64, 80, 81,
			90, 91, 95, 96, 98, 99: ok = 1'b1;
			FN_CUR_AVG: ok = !relay;
			default: ok = 1'b0;
		endcase
		return ok;
	endfunction

endpackage

// ### hw/sdos_func_if.sv
// Purpose: Carries the internal function vector and terminal codes to the output selectors.
// Assumes: One driver of the vector, any number of readers.
// Notes:   Codes travel already registered.
`timescale 1ns/10ps
interface sdos_func_if;
	import sdos_pkg::*;

	logic [FUNC_N-1:0] func_vec;
	logic [SEL_W-1:0]  term_sel [TERM_N];

	modport src  (output func_vec, output term_sel);
	modport sink (input func_vec, input term_sel);
endinterface

// ### hw/term_select.sv
// Purpose: Maps one selection code to one output terminal level.
// Assumes: Codes and functions are on the core clock.
// Notes:   Output is registered; a code outside the permitted set drives a steady low.
`timescale 1ns/10ps
module term_select
	import sdos_pkg::*;
#(
	parameter int          IDX   = 0,
	parameter logic        RELAY = 1'b0
) (
	input  wire logic       i_core_clk, // Core clock.
	input  wire logic       i_reset,    // Synchronous reset, high.
	sdos_func_if.sink       fbus,       // Function vector and codes.
	output      logic       o_term      // Terminal level.
);

	// ********************************************************
	// Code decode
	// ********************************************************
	logic [SEL_W-1:0] code;
	logic             is_sink;
	logic [SEL_W-1:0] base;
	logic             legal;
	logic             func_val;
	logic             term_next;
	logic             term_reg;

	// Codes 100 to 199 select code minus 100 with inverted (sink) sense.
	assign code      = fbus.term_sel[IDX];
	assign is_sink   = (code >= SINK_OFFSET) && (code <= SINK_MAX);
	assign base      = is_sink ? code - SINK_OFFSET : code;
	assign legal     = (code <= SINK_MAX) && code_allowed(base, RELAY);
	assign func_val  = legal ? fbus.func_vec[base[6:0]] : 1'b0;
	assign term_next = legal ? (func_val ^ is_sink) : 1'b0;

	// Terminal register.
	always_ff @(posedge i_core_clk) begin
		if (i_reset) begin
			term_reg <= 1'b0;
		end else begin
			term_reg <= term_next;
		end
	end

	assign o_term = term_reg;

endmodule

// ### dv/sdos_monitor.sv
// Purpose: Concurrent checks on the start decode and output select ports.
// Assumes: Pins steady for five edges have crossed the synchronisers.
// Notes:   Bound to the top module; sees its ports only.
`timescale 1ns/10ps
module sdos_monitor
	import sdos_pkg::*;
(
	input  wire logic              i_core_clk,           // Clock.
	input  wire logic              i_reset,              // Reset.
	input  wire logic              i_forward_start_in,   // Forward pin.
	input  wire logic              i_reverse_start_in,   // Reverse pin.
	input  wire logic              i_stop_hold_in,       // Stop-hold pin.
	input  wire logic              i_jog_in,             // Jog pin.
	input  wire logic              i_output_stop_in,     // Output-stop pin.
	input  wire logic              i_jog_enable,         // Jog allowed.
	input  wire logic [SEL_W-1:0]  i_start_selection,    // Start setting.
	input  wire logic [SEL_W-1:0]  i_run_terminal_sel,   // Run code.
	input  wire logic [SEL_W-1:0]  i_relay_terminal_sel, // Relay code.
	input  wire logic              i_stall_active,       // Stall.
	input  wire logic [PCT_W-1:0]  i_thermal_pct,        // Thermal level.
	input  wire logic              o_run_cmd,            // Run.
	input  wire logic              o_dir_reverse,        // Direction.
	input  wire logic              o_output_on,          // Output on.
	input  wire logic              o_thermal_trip,       // Trip.
	input  wire logic              o_run_term,           // Run terminal.
	input  wire logic              o_relay_term          // Relay terminal.
);
	// ********************************
	// Start decode and terminal checks
	// ********************************
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (i_reset);

	// Pin patterns held long enough to reach the decoder.
	sequence s_two_fwd;
		(i_start_selection == SEL_NONE && i_forward_start_in && !i_reverse_start_in
			&& !i_stop_hold_in)[*5];
	endsequence
	sequence s_two_both;
		(i_start_selection == SEL_NONE && i_forward_start_in && i_reverse_start_in
			&& !i_stop_hold_in)[*5];
	endsequence
	sequence s_rundir_both;
		(i_start_selection == START_RUNDIR_DEC && i_forward_start_in && i_reverse_start_in
			&& !i_stop_hold_in)[*5];
	endsequence
	sequence s_jog_hold;
		(i_start_selection == SEL_NONE && i_stop_hold_in && i_jog_in && i_jog_enable
			&& !i_forward_start_in && !i_reverse_start_in)[*5];
	endsequence

	a_two_start_fwd: assert property (s_two_fwd |-> o_run_cmd && !o_dir_reverse)
		else $error("forward alone did not run forward");
	a_two_start_both: assert property (s_two_both |-> !o_run_cmd)
		else $error("both starts did not stop");
	a_rundir_reverse: assert property (s_rundir_both |-> o_run_cmd && o_dir_reverse)
		else $error("run and direction did not reverse");
	a_jog_skips_hold: assert property (s_jog_hold |-> !o_run_cmd)
		else $error("stop-hold kept a start during jog");
	a_stop_cuts_out: assert property (i_output_stop_in[*5] |-> !o_output_on)
		else $error("output stayed on under output stop");
	a_trip_sticky: assert property (o_thermal_trip |=> o_thermal_trip && !o_output_on)
		else $error("trip released or output left on");
	a_trip_level: assert property (i_thermal_pct >= TRIP_PCT |-> ##[1:3] o_thermal_trip)
		else $error("no trip at full thermal level");
	a_relay_refuse: assert property ((i_relay_terminal_sel == 14'h00C1)[*3] |-> !o_relay_term)
		else $error("relay took the pulse monitor code");
	a_code_none_off: assert property ((i_run_terminal_sel == SEL_NONE)[*3] |-> !o_run_term)
		else $error("unused run terminal active");
	a_overload_sense: assert property ((i_stall_active && (i_run_terminal_sel == 14'h0003
		|| i_run_terminal_sel == 14'h0067))[*3] |-> o_run_term == (i_run_terminal_sel == 14'h0003))
		else $error("overload terminal sense wrong");
endmodule

bind start_decode_output_select sdos_monitor i_sdos_monitor (
	.i_core_clk(i_core_clk), .i_reset(i_reset), .i_forward_start_in(i_forward_start_in),
	.i_reverse_start_in(i_reverse_start_in), .i_stop_hold_in(i_stop_hold_in),
	.i_jog_in(i_jog_in), .i_output_stop_in(i_output_stop_in), .i_jog_enable(i_jog_enable),
	.i_start_selection(i_start_selection), .i_run_terminal_sel(i_run_terminal_sel),
	.i_relay_terminal_sel(i_relay_terminal_sel), .i_stall_active(i_stall_active),
	.i_thermal_pct(i_thermal_pct), .o_run_cmd(o_run_cmd), .o_dir_reverse(o_dir_reverse),
	.o_output_on(o_output_on), .o_thermal_trip(o_thermal_trip), .o_run_term(o_run_term),
	.o_relay_term(o_relay_term)
);

// ### dv/plc_model.sv
// Purpose: Behavioural controller driving the start, stop-hold, jog and output-stop pins.
// Assumes: The controller scans once a cycle on the falling edge.
// Notes:   Each command reaches the pins one scan later.
`timescale 1ns/10ps
module plc_model (
	input  wire logic       i_core_clk, // Core clock.
	input  wire logic [4:0] i_cmd,      // Output stop, jog, hold, reverse, forward.
	output      logic [4:0] o_pins      // Pin levels.
);
	// Pins copy the command at each scan, so every level lasts a whole cycle.
	initial o_pins = 5'h0;
	always @(negedge i_core_clk) begin
		o_pins <= i_cmd;
	end
endmodule

// ### dv/start_decode_output_select_test.sv
// Purpose: Self-checking bench for start decode and output select.
// Assumes: Settling eight cycles covers synchronisers and output registers.
// Notes:   Expected levels are queued and compared on each sample event.
`timescale 1ns/10ps
module start_decode_output_select_test;
	import sdos_pkg::*;

	// ****************************
	// Signals
	// ****************************
	logic              i_core_clk = 1'b0;
	logic              i_reset = 1'b1;
	logic [4:0]        cmd = 5'h00;
	wire  logic [4:0]  pins;
	wire  logic        i_forward_start_in, i_reverse_start_in, i_stop_hold_in;
	wire  logic        i_jog_in, i_output_stop_in;
	logic              i_jog_enable = 1'b0, i_stall_active = 1'b0, i_fault_active = 1'b1;
	logic [SEL_W-1:0]  i_start_selection = SEL_NONE, i_run_terminal_sel = RUN_SEL_RST;
	logic [SEL_W-1:0]  i_freq_terminal_sel = FREQ_SEL_RST, i_relay_terminal_sel = RELAY_SEL_RST;
	logic [FREQ_W-1:0] i_out_freq = '0, i_start_freq = '0, i_set_freq = '0;
	logic [FREQ_W-1:0] i_detect_freq_fwd = '0, i_detect_freq_rev = '0;
	logic [FREQ_W-1:0] i_out_current = '0, i_current_limit = 16'h0064;
	logic [PCT_W-1:0]  i_regen_usage_pct = '0, i_thermal_pct = '0;
	logic [23:0]       i_current_qual = 24'h00_0003;
	logic              o_run_cmd, o_dir_reverse, o_output_on, o_coast_stop, o_jog_active;
	logic              o_thermal_trip, o_run_term, o_freq_term, o_relay_term;
	logic [8:0]        outs;
	logic [SEL_W-1:0]  sel [3];
	logic              sk;
	int                fail_count = 0, n_tests = 0, cycles = 0, k;
	int                codes [10] = '{0, 1, 3, 4, 7, 8, 11, 99, 2, 9999};
	int                modes [4] = '{9999, 50, 8888, 1050};
	typedef struct {string nm; int idx; logic exp;} note_s;
	note_s             notes [$];
	event              sample;

	assign {i_output_stop_in, i_jog_in, i_stop_hold_in, i_reverse_start_in, i_forward_start_in} = pins;
	assign outs = {o_relay_term, o_freq_term, o_run_term, o_thermal_trip, o_jog_active,
		o_coast_stop, o_output_on, o_dir_reverse, o_run_cmd};

	start_decode_output_select i_start_decode_output_select (.*);
	plc_model i_plc_model (.i_core_clk(i_core_clk), .i_cmd(cmd), .o_pins(pins));

	// Clock and a hang guard.
	always #5 i_core_clk = ~i_core_clk;
	always @(posedge i_core_clk) begin
		cycles++;
		if (cycles == 5000) begin
			fail_count++;
			stop_test();
		end
	end

	// ****************************
	// Tasks and expectations
	// ****************************
	task automatic check(input string nm, input logic exp, input logic seen);
		n_tests++;
		if (seen !== exp) begin
			fail_count++;
			$display("CHECK FAILED %s expected %b seen %b", nm, exp, seen);
		end
	endtask
	task automatic note(input string nm, input int idx, input logic exp);
		notes.push_back('{nm, idx, exp});
	endtask
	task automatic settle(input int n);
		repeat (n) @(negedge i_core_clk);
		-> sample;
		#1;
	endtask
	task automatic stop_test();
		$display("Comparisons %0d, mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	function automatic logic [FREQ_W-1:0] rf();
		return FREQ_W'($urandom_range(200));
	endfunction
	// Level of a source-logic function for the present inputs.
	function automatic logic fn_level(input int code, input logic on);
		case (code)
			0: return on && i_out_freq >= i_start_freq;
			1: return on && i_out_freq >= i_set_freq;
			3: return i_stall_active;
			4: return i_out_freq >= i_detect_freq_fwd;
			7: return i_regen_usage_pct >= PREALARM_PCT;
			8: return i_thermal_pct >= PREALARM_PCT;
			11: return !i_fault_active || (on && i_out_freq >= i_start_freq);
			99: return i_fault_active;
			default: return 1'b0;
		endcase
	endfunction

	// Every queued note is compared with the outputs, oldest first, whenever a sample is taken.
	always @(sample) begin
		while (notes.size() > 0) begin
			check(notes[0].nm, notes[0].exp, outs[notes[0].idx]);
			void'(notes.pop_front());
		end
	end

	// ****************************
	// Main sequence
	// ****************************
	initial begin
		void'($urandom(70282));
		repeat (12) @(negedge i_core_clk);
		i_reset = 1'b0;
		note("relay", 8, 1'b1);
		note("freq", 7, 1'b1);
		note("run_t", 6, 1'b0);
		settle(4);
		i_fault_active = 1'b0;
		for (int m = 0; m < 4; m++) begin
			i_start_selection = SEL_W'(modes[m]);
			for (int c = 0; c < 4; c++) begin
				cmd = {3'h0, c[1:0]};
				note("run", 0, m > 1 ? c[0] : c[0] ^ c[1]);
				note("coast", 3, m == 1 || m == 3);
				if (m > 1 ? c[0] : c[0] ^ c[1]) note("dir", 1, c[1]);
				settle(8);
			end
		end
		i_start_selection = SEL_NONE;
		cmd = 5'h04;
		settle(6);
		cmd = 5'h05;
		settle(4);
		cmd = 5'h04;
		note("run", 0, 1'b1);
		note("dir", 1, 1'b0);
		settle(8);
		cmd = 5'h14;
		note("on", 2, 1'b0);
		settle(8);
		cmd = 5'h04;
		note("on", 2, 1'b1);
		settle(8);
		cmd = 5'h06;
		settle(4);
		cmd = 5'h04;
		note("dir", 1, 1'b1);
		settle(8);
		i_jog_enable = 1'b1;
		cmd = 5'h0C;
		note("run", 0, 1'b0);
		note("jog", 4, 1'b1);
		settle(8);
		i_jog_enable = 1'b0;
		cmd = 5'h01;
		settle(8);
		// Random settings against codes 0, 1, 3, 4, 7, 8, 11 and 99 in both senses, plus codes 2 and 9999.
		for (int t = 0; t < 24; t++) begin
			{i_out_freq, i_start_freq, i_set_freq} = {rf(), rf(), rf()};
			{i_detect_freq_fwd, i_detect_freq_rev} = {rf(), rf()};
			{i_stall_active, i_fault_active} = 2'($urandom);
			i_regen_usage_pct = PCT_W'($urandom_range(99));
			i_thermal_pct = PCT_W'($urandom_range(99));
			cmd = {4'h0, 1'($urandom)};
			for (int j = 0; j < 3; j++) begin
				k = $urandom_range(9);
				sk = 1'($urandom) && k < 8;
				sel[j] = SEL_W'(codes[k] + (sk ? 100 : 0));
				note("term", 6 + j, k < 8 && (fn_level(codes[k], cmd[0]) ^ sk));
			end
			{i_run_terminal_sel, i_freq_terminal_sel, i_relay_terminal_sel} = {sel[0], sel[1], sel[2]};
			settle(8);
		end
		{cmd, i_fault_active, i_freq_terminal_sel} = {5'h02, 1'b0, FREQ_SEL_RST};
		{i_out_freq, i_detect_freq_fwd, i_detect_freq_rev} = {16'h0064, 16'h0032, 16'h0096};
		note("freq", 7, 1'b0);
		settle(8);
		i_detect_freq_rev = 16'h0050;
		note("freq", 7, 1'b1);
		settle(8);
		{i_run_terminal_sel, i_relay_terminal_sel} = {14'h00C1, 14'h00C1};
		note("run_t", 6, 1'b1);
		note("relay", 8, 1'b0);
		settle(6);
		{i_run_terminal_sel, i_out_current} = {14'h000C, 16'h00C8};
		note("cur", 6, 1'b0);
		settle(3);
		note("cur", 6, 1'b1);
		settle(7);
		i_out_current = 16'h0000;
		note("cur", 6, 1'b0);
		settle(4);
		{i_relay_terminal_sel, i_thermal_pct} = {RELAY_SEL_RST, TRIP_PCT};
		note("trip", 5, 1'b1);
		note("on", 2, 1'b0);
		note("relay", 8, 1'b1);
		settle(8);
		stop_test();
	end
endmodule
